// File: hdl/dsop_core.sv
// Status and output port of the deterministic random bit generator core.
`timescale 1ns/10ps
module dsop_core
  import dsop_pkg::*;
(
  input  wire logic               mclk_i,
  input  wire logic               rst_n_i,
  input  wire logic               enable_i,
  input  wire logic               start_i,
  input  wire logic [1:0]         command_i,
  input  wire logic               test_req_i,
  input  wire logic               kat_fail_i,
  input  wire logic               noise_fault_i,
  input  wire logic [dsop_pkg::AW-1:0] addr_i,
  input  wire logic [dsop_pkg::DW-1:0] wdata_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  output logic      [dsop_pkg::DW-1:0] rdata_o,
  output logic                    busy_o,
  output logic                    bits_valid_o,
  output logic      [dsop_pkg::DW-1:0] bits_o,
  output logic                    status_valid_o,
  output logic                    lockup_o,
  output logic                    error_o,
  output logic                    irq_o
);

  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------
  dsop_state_t     st_r;       // Operation sequencer state.
  dsop_cmd_t       cmd_r;      // Command of the running operation.
  logic [CW-1:0]   cnt_r;      // Cycle or word count within an operation.
  logic            err_acc_r;  // Noise fault seen in this operation.
  logic            busy_r;     // Busy output flop.
  logic            bv_r;       // Word strobe flop.
  logic [DW-1:0]   bits_r;     // Output word flop.
  logic            sv_r;       // Outcome strobe flop.
  logic            lock_r;     // Lockup flag flop.
  logic            err_r;      // Per-operation error flop.
  logic [EV_W-1:0] irq_st_r;   // Sticky event bits.
  logic [EV_W-1:0] irq_st_nxt; // Next sticky event bits.
  logic [EV_W-1:0] irq_mk_r;   // Interrupt mask.
  logic            irq_r;      // Interrupt output flop.
  logic [CW-1:0]   gen_len_r;  // Words per generate minus one.
  logic [DW-1:0]   seed_r;     // Seed loaded on instantiate or reseed.
  logic [DW-1:0]   rdata_r;    // Read data flop.
  logic [DW-1:0]   word;       // Word from the generator.
  logic            accept;     // A command is taken this edge.
  logic            run_last;   // Final cycle of a running operation.
  logic            test_end;   // Self test ends this edge.
  logic            gen_adv;    // Step the generator.
  logic            gen_load;   // Reseed the generator.
  logic [EV_W-1:0] ev;         // Events raised this edge.

  // Address match, shared by the read and the write decode.
  function automatic logic hit(input logic [AW-1:0] a,
                               input logic [AW-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ---------------------------------------------------------------------
  // Sequencer control terms
  // ---------------------------------------------------------------------

  // A command is only taken from idle once busy has dropped, so a start
  // raised beside the outcome strobe is ignored rather than queued.
  always_comb
  begin
    accept   = enable_i && (st_r == ST_IDLE) && !busy_r && !lock_r
               && (start_i || test_req_i);
    run_last = enable_i && (st_r == ST_RUN) &&
               (cnt_r == ((cmd_r == CMD_GEN) ? gen_len_r : OP_LAST));
    test_end = enable_i && (st_r == ST_TEST) &&
               (kat_fail_i || (cnt_r == KAT_LAST));
    gen_adv  = enable_i && (st_r == ST_RUN) && (cmd_r == CMD_GEN);
    gen_load = run_last && ((cmd_r == CMD_INST) || (cmd_r == CMD_RESEED));
  end

  // ---------------------------------------------------------------------
  // Operation sequencer
  // ---------------------------------------------------------------------

  // Reset starts with the self test, as a power-on check. Nothing moves
  // while enable is low, so the operation simply pauses.
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      st_r      <= ST_TEST;
      cmd_r     <= CMD_INST;
      cnt_r     <= '0;
      err_acc_r <= 1'b0;
    end
    else if (enable_i)
    begin
      case (st_r)
        ST_IDLE:
        begin
          // Self test request takes priority over a plain start.
          if (accept && test_req_i)
          begin
            st_r  <= ST_TEST;
            cnt_r <= '0;
          end
          else if (accept)
          begin
            st_r      <= ST_RUN;
            cmd_r     <= dsop_cmd_t'(command_i);
            cnt_r     <= '0;
            err_acc_r <= noise_fault_i;
          end
        end
        ST_TEST:
        begin
          // A known-answer mismatch locks the core for good.
          if (kat_fail_i)
            st_r <= ST_LOCK;
          else if (test_end)
            st_r <= ST_IDLE;
          else
            cnt_r <= cnt_r + 1'b1;
        end
        ST_RUN:
        begin
          err_acc_r <= err_acc_r | noise_fault_i;
          if (run_last)
            st_r <= ST_IDLE;
          else
            cnt_r <= cnt_r + 1'b1;
        end
        ST_LOCK:
          st_r <= ST_LOCK;
        default:
          st_r <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Word source
  // ---------------------------------------------------------------------
  dsop_word_gen u_gen (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .load_i  (gen_load),
    .seed_i  (seed_r),
    .adv_i   (gen_adv),
    .word_o  (word)
  );

  // ---------------------------------------------------------------------
  // Operation outputs
  // ---------------------------------------------------------------------

  // Busy covers every cycle from the accepting edge up to and including
  // the cycle that shows the outcome strobe.
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      busy_r <= 1'b1;
    else if (enable_i)
      busy_r <= (st_r == ST_RUN) || (st_r == ST_TEST) || accept;
  end

  // One word per cycle of a generate; the last word shares its cycle
  // with the outcome strobe.
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      bv_r   <= 1'b0;
      bits_r <= ZERO_W;
    end
    else
    begin
      bv_r <= gen_adv;
      if (gen_adv)
        bits_r <= word;
    end
  end

  // The strobe is a single cycle; a paused core shows no strobe at all.
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      sv_r <= 1'b0;
    else
      sv_r <= run_last || test_end;
  end

  // The error flag is cleared when a command is taken and set from the
  // faults of that one operation, then held until the next command.
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      err_r <= 1'b0;
    else if (accept)
      err_r <= 1'b0;
    else if (run_last)
      err_r <= err_acc_r | noise_fault_i;
  end

  // Only a reset clears the lockup flag; it rises with the strobe.
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      lock_r <= 1'b0;
    else if (test_end && kat_fail_i)
      lock_r <= 1'b1;
  end

  // ---------------------------------------------------------------------
  // Interrupt events
  // ---------------------------------------------------------------------

  // A write-one clear loses against an event landing in the same cycle.
  always_comb
  begin
    ev          = '0;
    ev[EV_DONE] = run_last || test_end;
    ev[EV_ERR]  = run_last && (err_acc_r || noise_fault_i);
    ev[EV_LOCK] = test_end && kat_fail_i;
    irq_st_nxt  = irq_st_r;
    if (wr_i && hit(addr_i, OFS_IRQ_STAT))
      irq_st_nxt = irq_st_nxt & ~wdata_i[EV_W-1:0];
    irq_st_nxt = irq_st_nxt | ev;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      irq_st_r <= '0;
      irq_r    <= 1'b0;
    end
    else
    begin
      irq_st_r <= irq_st_nxt;
      irq_r    <= |(irq_st_nxt & irq_mk_r);
    end
  end

  // ---------------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------------

  // Changing the length mid-generate changes where that generate ends;
  // software is expected to write it only while the core is idle.
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      irq_mk_r  <= MASK_RST;
      gen_len_r <= GEN_LEN_RST;
      seed_r    <= SEED_RST;
    end
    else if (wr_i)
    begin
      if (hit(addr_i, OFS_IRQ_MASK))
        irq_mk_r <= wdata_i[EV_W-1:0];
      if (hit(addr_i, OFS_GEN_LEN))
        gen_len_r <= wdata_i[CW-1:0];
      if (hit(addr_i, OFS_SEED))
        seed_r <= wdata_i;
    end
  end

  // ---------------------------------------------------------------------
  // Register reads
  // ---------------------------------------------------------------------

  // Data stand for exactly the cycle after the read strobe; unmapped
  // addresses and idle cycles read as zero.
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      rdata_r <= ZERO_W;
    else
    begin
      rdata_r <= ZERO_W;
      if (rd_i)
      begin
        if (hit(addr_i, OFS_STATE))
        begin
          rdata_r[ST_BUSY_BIT] <= busy_r;
          rdata_r[ST_LOCK_BIT] <= lock_r;
          rdata_r[ST_ERR_BIT]  <= err_r;
          rdata_r[ST_FSM_LSB +: 3] <= st_r;
        end
        else if (hit(addr_i, OFS_IRQ_STAT))
          rdata_r[EV_W-1:0] <= irq_st_r;
        else if (hit(addr_i, OFS_IRQ_MASK))
          rdata_r[EV_W-1:0] <= irq_mk_r;
        else if (hit(addr_i, OFS_GEN_LEN))
          rdata_r[CW-1:0] <= gen_len_r;
        else if (hit(addr_i, OFS_SEED))
          rdata_r <= seed_r;
        else if (hit(addr_i, OFS_LAST))
          rdata_r <= bits_r;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign rdata_o        = rdata_r;
  assign busy_o         = busy_r;
  assign bits_valid_o   = bv_r;
  assign bits_o         = bits_r;
  assign status_valid_o = sv_r;
  assign lockup_o       = lock_r;
  assign error_o        = err_r;
  assign irq_o          = irq_r;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // Outcome strobe never appears outside a busy period.
  busy_cover_a: assert property (status_valid_o |-> busy_o)
    else $error("outcome strobe without busy");

  // Words only appear while a generate runs.
  word_busy_a: assert property (bits_valid_o |-> busy_o && !lockup_o)
    else $error("word strobe outside a generate");

  // Words of a generate come back to back until its last one.
  word_train_a: assert property
    (bits_valid_o && !status_valid_o && enable_i |=> bits_valid_o)
    else $error("word train broken");

  // Lockup always rises together with the outcome strobe.
  lock_strobe_a: assert property ($rose(lockup_o) |-> status_valid_o)
    else $error("lockup rose without outcome strobe");

  // The last generate word carries the outcome strobe.
  last_word_a: assert property
    ((bits_valid_o && enable_i) ##1 !bits_valid_o |-> $past(status_valid_o))
    else $error("last word without outcome strobe");

  // Lockup never falls without reset.
  lock_hold_a: assert property (lockup_o |=> lockup_o)
    else $error("lockup cleared without reset");

  // A locked core never starts anything.
  lock_refuse_a: assert property
    (lockup_o && start_i |=> st_r == ST_LOCK && !bits_valid_o)
    else $error("locked core took a command");

  // After an errored operation a fresh start is still taken.
  err_continue_a: assert property
    (st_r == ST_IDLE && !busy_o && !lockup_o && enable_i && start_i
     && !test_req_i |=> st_r == ST_RUN ##0 !error_o)
    else $error("start refused after an error");

  // A noise fault inside an operation reaches the error flag.
  fault_err_a: assert property
    (st_r == ST_RUN && enable_i && noise_fault_i
     |=> err_acc_r || (status_valid_o && error_o))
    else $error("noise fault lost");

  // Start during busy leaves the sequencer idle.
  busy_ignore_a: assert property
    (st_r == ST_IDLE && busy_o && start_i |=> st_r == ST_IDLE)
    else $error("start taken while busy");

  // Self test mismatch locks the core on the next edge.
  kat_lock_a: assert property
    (st_r == ST_TEST && enable_i && kat_fail_i |=> lockup_o)
    else $error("self test failure did not lock");

  // Disabled core holds its sequencer still.
  enable_hold_a: assert property
    (!enable_i |=> $stable(st_r) && $stable(cnt_r) && !status_valid_o)
    else $error("core moved while disabled");

  // Outcome strobe is a single cycle.
  strobe_once_a: assert property (status_valid_o |=> !status_valid_o)
    else $error("outcome strobe longer than one cycle");

endmodule : dsop_core

// File: hdl/dsop_pkg.sv
// Package of constants and types shared by the generator status/output port.
package dsop_pkg;

  // ---------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------
  localparam int unsigned DW = 32; // Random word and register data width.
  localparam int unsigned AW = 8;  // Register address width.
  localparam int unsigned CW = 8;  // Width of the operation cycle counter.

  // ---------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------
  localparam logic [AW-1:0] OFS_STATE    = 8'h00; // Core state, read only.
  localparam logic [AW-1:0] OFS_IRQ_STAT = 8'h04; // Sticky events, W1C.
  localparam logic [AW-1:0] OFS_IRQ_MASK = 8'h08; // Interrupt enables.
  localparam logic [AW-1:0] OFS_GEN_LEN  = 8'h0C; // Words per generate - 1.
  localparam logic [AW-1:0] OFS_SEED     = 8'h10; // Seed for reseed.
  localparam logic [AW-1:0] OFS_LAST     = 8'h14; // Last word delivered.

  // ---------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------
  localparam int unsigned ST_BUSY_BIT = 0; // State register: busy.
  localparam int unsigned ST_LOCK_BIT = 1; // State register: lockup.
  localparam int unsigned ST_ERR_BIT  = 2; // State register: last error.
  localparam int unsigned ST_FSM_LSB  = 4; // State register: fsm code.
  localparam int unsigned EV_DONE     = 0; // Event: operation done.
  localparam int unsigned EV_ERR      = 1; // Event: operation error.
  localparam int unsigned EV_LOCK     = 2; // Event: lockup entered.
  localparam int unsigned EV_W        = 3; // Number of event bits.
  localparam logic [EV_W-1:0] MASK_RST    = 3'h0;
  localparam logic [CW-1:0]   GEN_LEN_RST = 8'h03;
  // Arbitrary seed value, chosen only so the generator never starts at 0.
  localparam logic [DW-1:0]   SEED_RST    = 32'h1F2E_3D4C;
  localparam logic [DW-1:0]   ZERO_W      = 32'h0000_0000;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;   // 25 MHz clock.
  localparam int unsigned OP_TIME_NS    = 160;  // Non-generate op length.
  localparam int unsigned KAT_TIME_NS   = 4000; // Self test length.
  localparam logic [CW-1:0] OP_LAST  =
    CW'((OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);
  localparam logic [CW-1:0] KAT_LAST =
    CW'((KAT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);

  // ---------------------------------------------------------------------
  // Commands and states
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    CMD_INST   = 2'h0,
    CMD_UNINST = 2'h1,
    CMD_RESEED = 2'h2,
    CMD_GEN    = 2'h3
  } dsop_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_TEST = 3'h1,
    ST_RUN  = 3'h2,
    ST_LOCK = 3'h3
  } dsop_state_t;

endpackage : dsop_pkg

// File: hdl/dsop_word_gen.sv
// Word source standing in for the cipher datapath: a registered xorshift.
`timescale 1ns/10ps
module dsop_word_gen
  import dsop_pkg::*;
(
  input  wire logic               mclk_i,
  input  wire logic               rst_n_i,
  input  wire logic               load_i,
  input  wire logic [dsop_pkg::DW-1:0] seed_i,
  input  wire logic               adv_i,
  output logic      [dsop_pkg::DW-1:0] word_o
);

  // ---------------------------------------------------------------------
  // Generator state
  // ---------------------------------------------------------------------
  logic [DW-1:0] s_r;   // Current state, also the word presented.
  logic [DW-1:0] s_nxt; // State after one step.
  logic [DW-1:0] t1;    // First shift stage.
  logic [DW-1:0] t2;    // Second shift stage.

  // One xorshift step; a zero seed would stick, so it is replaced.
  always_comb
  begin
    t1    = s_r ^ (s_r << 13);
    t2    = t1 ^ (t1 >> 17);
    s_nxt = t2 ^ (t2 << 5);
  end

  // The word is read straight from the state register.
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      s_r <= SEED_RST;
    else if (load_i)
      s_r <= (seed_i == ZERO_W) ? SEED_RST : seed_i;
    else if (adv_i)
      s_r <= s_nxt;
  end

  assign word_o = s_r;

endmodule : dsop_word_gen

// File: bench/dsop_user_model.sv
// Far-side user logic model: entropy fault source and word consumer.
`timescale 1ns/10ps
module dsop_user_model
  import dsop_pkg::*;
(
  input  wire logic                    mclk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    unsafe_i,
  input  wire logic                    bits_valid_i,
  input  wire logic [dsop_pkg::DW-1:0] bits_i,
  output logic                         noise_fault_o,
  output logic      [15:0]             words_o,
  output logic      [dsop_pkg::DW-1:0] last_o
);
  // ---------------------------------------------------------------
  // Entropy source
  // ---------------------------------------------------------------
  // The fault is raised for exactly as long as the source is unsafe.
  assign noise_fault_o = unsafe_i;

  // ---------------------------------------------------------------
  // Word consumer
  // ---------------------------------------------------------------
  // Counts every strobed word and keeps the latest one, so the bench
  // can judge word counts without trusting the core's own registers.
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      words_o <= 16'h0000;
      last_o  <= ZERO_W;
    end
    else if (bits_valid_i)
    begin
      words_o <= words_o + 16'h0001;
      last_o  <= bits_i;
    end
  end
endmodule : dsop_user_model

// File: bench/testbench.sv
// Self-checking bench for the generator status and output port.
`timescale 1ns/10ps
`define CHK(g, e) chk(32'(g), 32'(e))
module testbench;
  import dsop_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic          mclk_i = 1'b0;      // Core clock.
  logic          rst_n_i = 1'b0;     // Reset, active low.
  logic          enable_i = 1'b1;    // Core enable.
  logic          start_i = 1'b0;     // Command start.
  logic [1:0]    command_i = 2'h0;   // Command code.
  logic          test_req_i = 1'b0;  // Self test request.
  logic          kat_fail_i = 1'b0;  // Self test mismatch.
  logic          unsafe = 1'b0;      // Entropy source unsafe.
  logic [AW-1:0] addr_i = 8'h00;     // Register address.
  logic [DW-1:0] wdata_i = ZERO_W;   // Register write data.
  logic          wr_i = 1'b0;        // Write strobe.
  logic          rd_i = 1'b0;        // Read strobe.
  logic [DW-1:0] rdata_o;            // Read data.
  logic          busy_o;             // Busy level.
  logic          bits_valid_o;       // Word strobe.
  logic [DW-1:0] bits_o;             // Random word.
  logic          status_valid_o;     // Outcome strobe.
  logic          lockup_o;           // Lockup flag.
  logic          error_o;            // Operation error.
  logic          irq_o;              // Interrupt.
  logic          fault;              // Noise fault from the model.
  logic [15:0]   words;              // Words seen by the model.
  logic [DW-1:0] last_w;             // Last word seen by the model.
  int            n_errors = 0;       // Mismatches.
  int            num_checks = 0;     // Comparisons.
  int            cyc = 0;            // Cycles run.

  // ---------------------------------------------------------------
  // Instances and clock
  // ---------------------------------------------------------------
  always #(CLK_PERIOD_NS / 2) mclk_i = ~mclk_i;

  dsop_core u_dsop_core (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .enable_i(enable_i),
    .start_i(start_i), .command_i(command_i), .test_req_i(test_req_i),
    .kat_fail_i(kat_fail_i), .noise_fault_i(fault), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .busy_o(busy_o), .bits_valid_o(bits_valid_o), .bits_o(bits_o),
    .status_valid_o(status_valid_o), .lockup_o(lockup_o),
    .error_o(error_o), .irq_o(irq_o));

  dsop_user_model u_dsop_user_model (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .unsafe_i(unsafe),
    .bits_valid_i(bits_valid_o), .bits_i(bits_o),
    .noise_fault_o(fault), .words_o(words), .last_o(last_w));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge mclk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe edge.
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge mclk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd

  task automatic wait_st();
    int n;
    n = 0;
    while ((status_valid_o !== 1'b1) && (n < 300))
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    `CHK(n < 300, 1'b1);
  endtask : wait_st

  task automatic do_reset();
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    wait_st();
    `CHK(busy_o, 1'b1);
    `CHK(lockup_o, 1'b0);
    @(posedge mclk_i);
    #1;
    `CHK(busy_o, 1'b0);
  endtask : do_reset

  // Runs one command; pz low-enable cycles from cycle 2, and a second
  // start in cycle rs+1 that a busy core must ignore.
  task automatic run_op(input logic [1:0] cmd, input int pz,
                        input int rs, output int n, output logic err);
    n = 0;
    @(posedge mclk_i);
    start_i   <= 1'b1;
    command_i <= cmd;
    while (n < 300)
    begin
      @(posedge mclk_i);
      start_i  <= (n == rs);
      enable_i <= (n < 1) || (n >= 1 + pz);
      #1;
      n++;
      `CHK(busy_o, 1'b1);
      `CHK(bits_valid_o, (cmd == CMD_GEN) && (n >= 2));
      if (status_valid_o === 1'b1)
        break;
    end
    err = error_o;
    @(posedge mclk_i);
    start_i <= 1'b0;
    #1;
    `CHK(status_valid_o, 1'b0);
    `CHK(busy_o, 1'b0);
  endtask : run_op

  task automatic chk_irq(input logic e);
    repeat (2) @(posedge mclk_i);
    #1;
    `CHK(irq_o, e);
  endtask : chk_irq

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    logic [DW-1:0] v;
    rd(OFS_GEN_LEN, v);
    `CHK(v, GEN_LEN_RST);
    rd(OFS_IRQ_MASK, v);
    `CHK(v, MASK_RST);
    rd(OFS_SEED, v);
    `CHK(v, SEED_RST);
    wr(OFS_STATE, 32'hFFFF_FFFF);
    rd(OFS_STATE, v);
    `CHK(v, ZERO_W);
    rd(8'h40, v);
    `CHK(v, ZERO_W);
  endtask : t_regs

  task automatic t_cmds();
    int   n;
    logic e;
    for (int c = 0; c < 3; c++)
    begin
      run_op(2'(c), 0, -1, n, e);
      `CHK(n, 5);
      `CHK(e, 1'b0);
    end
  endtask : t_cmds

  // One-word and six-word requests, each with a start while busy.
  task automatic t_gen();
    int            n;
    logic          e;
    logic [15:0]   w;
    logic [DW-1:0] v;
    for (int g = 0; g < 6; g += 5)
    begin
      wr(OFS_GEN_LEN, DW'(g));
      w = words;
      run_op(CMD_GEN, 0, (g == 0) ? 0 : g + 1, n, e);
      `CHK(n, g + 2);
      `CHK(words - w, g + 1);
      rd(OFS_LAST, v);
      `CHK(v, last_w);
      repeat (3) @(posedge mclk_i);
      #1;
      `CHK(busy_o, 1'b0);
    end
  endtask : t_gen

  task automatic t_fault();
    int            n;
    logic          e;
    logic [DW-1:0] v;
    @(posedge mclk_i);
    unsafe <= 1'b1;
    run_op(CMD_RESEED, 0, -1, n, e);
    `CHK(e, 1'b1);
    rd(OFS_STATE, v);
    `CHK(v, 32'h0000_0004);
    rd(OFS_IRQ_STAT, v);
    `CHK(v, 32'h0000_0003);
    @(posedge mclk_i);
    unsafe <= 1'b0;
    run_op(CMD_INST, 0, -1, n, e);
    `CHK(n, 5);
    `CHK(e, 1'b0);
  endtask : t_fault

  task automatic t_pause();
    int   n;
    logic e;
    run_op(CMD_UNINST, 3, -1, n, e);
    `CHK(n, 8);
  endtask : t_pause

  task automatic t_irq();
    int            n;
    logic          e;
    logic [DW-1:0] v;
    wr(OFS_IRQ_MASK, 32'h0000_0001);
    wr(OFS_IRQ_STAT, 32'h0000_0007);
    chk_irq(1'b0);
    run_op(CMD_INST, 0, -1, n, e);
    chk_irq(1'b1);
    rd(OFS_IRQ_STAT, v);
    `CHK(v, 32'h0000_0001);
    wr(OFS_IRQ_MASK, ZERO_W);
    chk_irq(1'b0);
  endtask : t_irq

  // A failed self test locks the core until the next reset.
  task automatic t_lock();
    logic [DW-1:0] v;
    @(posedge mclk_i);
    kat_fail_i <= 1'b1;
    test_req_i <= 1'b1;
    @(posedge mclk_i);
    test_req_i <= 1'b0;
    #1;
    wait_st();
    `CHK(lockup_o, 1'b1);
    @(posedge mclk_i);
    kat_fail_i <= 1'b0;
    start_i    <= 1'b1;
    command_i  <= CMD_GEN;
    repeat (8)
    begin
      @(posedge mclk_i);
      #1;
      `CHK(status_valid_o, 1'b0);
    end
    @(posedge mclk_i);
    start_i <= 1'b0;
    #1;
    `CHK(busy_o, 1'b0);
    `CHK(lockup_o, 1'b1);
    rd(OFS_STATE, v);
    `CHK(v, 32'h0000_0032);
    rd(OFS_IRQ_STAT, v);
    `CHK(v, 32'h0000_0005);
    do_reset();
  endtask : t_lock

  // ---------------------------------------------------------------
  // Main sequence and closing
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    if ((n_errors == 0) && (num_checks > 0))
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // The whole run needs about 360 cycles; the ceiling leaves room.
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_errors++;
      report_and_stop();
    end
  end

  initial
  begin
    do_reset();
    t_regs();
    t_cmds();
    t_gen();
    t_fault();
    t_pause();
    t_irq();
    t_lock();
    report_and_stop();
  end
endmodule : testbench
